// >>> rtl/fault_latch_pkg.sv
// Shared constants for the regulator fault latch block
package fault_latch_pkg;
  // Cycles of core_clk that undervoltage stays blanked after a transition
  localparam int unsigned BLANK_CYCLES = 32;
  localparam int unsigned BLANK_CNT_W = 6;
  // Register byte offsets on the bus
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_CLEAR_OFS = 8'h0c;
  localparam logic [7:0] INT_ENABLE_OFS = 8'h10;
  // Control register fields and reset values
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  // Status register fields
  localparam int unsigned ST_OV_BIT = 0;
  localparam int unsigned ST_UV_BIT = 1;
  localparam int unsigned ST_OT_BIT = 2;
  localparam int unsigned ST_BYPASS_BIT = 3;
  localparam int unsigned ST_BLANK_BIT = 4;
  localparam int unsigned ST_PG_BIT = 5;
  // Interrupt event bits, same layout in status, clear and enable
  localparam int unsigned NUM_EVENTS = 4;
  localparam int unsigned EV_OV_BIT = 0;
  localparam int unsigned EV_UV_BIT = 1;
  localparam int unsigned EV_OT_BIT = 2;
  localparam int unsigned EV_PG_LOSS_BIT = 3;
  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : fault_latch_pkg

// >>> rtl/regulator_fault_latch_logic.sv
// Fault latches, gate-drive forcing, power-good gating and register slave
// Operation
// Fault flags arrive thresholded and synchronous to core_clk
// Each fault owns a set-dominant latch in the state struct
// Clears come from shutdown held low, supply lockout or bypass
// Outside bypass, a flag still high and not blanked during a clear keeps its latch set
// Overvoltage and thermal drive the low side fully on
// Undervoltage only stops switching; both gates then rest low
// The high side is masked by the low side at the pin
// Power good and clock enable hold while the blank timer runs
// Overvoltage reaches both status pins with no flop between
// Clock enable low freezes all flops but not the comb overrides
// Bypass needs the high-voltage detector and a released pin
//
// Timing
// Overvoltage status: same cycle, through comb gating
// Fault latches and gate pins: the edge that samples the flag
// Clear sources act at the edge they are sampled on
// Blanking: the whole transition plus BLANK_CYCLES edges after it
// Register write: lands at the edge that ends its data phase
// Register read: data stands from the edge that takes the address
//
// Register map
// Control holds run enable; status shows latches, modes and power good
// Interrupt status, clear and enable share one event layout
// A write of ones to the clear register drops those bits
// An event in the same cycle as its clear is kept
//
// Limitations
// Flags are not filtered; a one-cycle glitch latches a fault
// The slave has no wait states and ignores hsize, so narrow writes act as words
// Outside bypass, a thermal restart also needs the flag low, so a hot die stays off
// Undervoltage blanking counts enabled clock edges only
// Power-good loss is an event even when a fault caused it
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_latch_logic #(
  parameter int unsigned BLANK_CYCLES = fault_latch_pkg::BLANK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic overvoltage_trip,
  input wire logic undervoltage_trip,
  input wire logic thermal_trip,
  input wire logic shutdown_n_in,
  input wire logic shutdown_hv_detect,
  input wire logic supply_lockout,
  input wire logic slew_active,
  input wire logic output_in_regulation,
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  output logic low_side_gate_drive,
  output logic high_side_gate_drive,
  output logic power_good_out,
  output logic cpu_clock_enable_n,
  output logic converter_running,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import fault_latch_pkg::*;

  typedef struct packed {
    // Fault latches
    logic ov;
    logic uv;
    logic ot;
    // Software-visible registers
    logic run_en;
    logic [NUM_EVENTS-1:0] int_status;
    logic [NUM_EVENTS-1:0] int_enable;
    // Registered pin values
    logic pg;
    logic cpu_clock_enable_n_n;
    logic ls;
    logic hs;
    // Bus pipeline
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
  } state_s;

  // State register and its next value
  state_s s_r;
  state_s s_nxt;
  // Mode decode
  logic blank;
  logic bypass;
  logic clear_latch;
  // Qualified fault sets
  logic ov_set;
  logic uv_set;
  logic ot_set;
  logic ov_now;
  // Helpers of the next-state process
  logic run_nxt;
  logic force_low;
  // Bus decode
  logic addr_accept;
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] clr_mask;

  // Undervoltage blanking window after each output transition
  slew_blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .slew_active(slew_active),
    .blank(blank)
  );

  // Bypass needs the high-voltage detector and a released shutdown pin
  assign bypass = shutdown_hv_detect & shutdown_n_in;

  // Latches clear while shutdown is held, under lockout, or in bypass
  assign clear_latch = ~shutdown_n_in | supply_lockout | bypass;

  // Comparator flags already encode the trip thresholds
  assign ov_set = overvoltage_trip & ~bypass;
  assign uv_set = undervoltage_trip & ~bypass & ~blank;
  assign ot_set = thermal_trip & ~bypass;

  // Overvoltage also acts before it is latched, with no cycle of delay
  assign ov_now = s_r.ov | ov_set;

  // Address phase is taken only while the bus is ready
  assign addr_accept = hsel & hready & htrans[1];

  // Next state: fault latches, gate drives, status gating and registers
  always_comb
  begin
    s_nxt = s_r;
    events = '0;
    clr_mask = '0;
    run_nxt = 1'b0;
    force_low = 1'b0;

    // A set in the same cycle as a clear wins, so a live fault stays latched
    s_nxt.ov = ov_set | (s_r.ov & ~clear_latch);
    s_nxt.uv = uv_set | (s_r.uv & ~clear_latch);
    // Outside bypass, thermal cannot clear while its flag is still high
    s_nxt.ot = ot_set | (s_r.ot & ~clear_latch);

    // Register writes land in the data phase after the address is taken
    if (s_r.wr_pend)
    begin
      case (s_r.wr_addr)
        CTRL_OFS:
        begin
          // Run enable lives in one bit
          s_nxt.run_en = hwdata[CTRL_RUN_BIT];
        end
        INT_CLEAR_OFS:
        begin
          // Write-one-to-clear of sticky events
          clr_mask = hwdata[NUM_EVENTS-1:0];
        end
        INT_ENABLE_OFS:
        begin
          // Enables use the event layout
          s_nxt.int_enable = hwdata[NUM_EVENTS-1:0];
        end
        STATUS_OFS,
        INT_STATUS_OFS:
        begin
          // Read-only registers ignore writes
          s_nxt.run_en = s_r.run_en;
        end
        default:
        begin
          // Unmapped offsets are ignored
          s_nxt.run_en = s_r.run_en;
        end
      endcase
    end

    // Converter may switch only with no latched fault and shutdown released
    run_nxt = s_nxt.run_en & shutdown_n_in & ~supply_lockout
              & ~s_nxt.ov & ~s_nxt.uv & ~s_nxt.ot;

    // Overvoltage and thermal force the synchronous rectifier fully on
    force_low = s_nxt.ov | s_nxt.ot;
    // Normal PWM: the low side only when the high side is not asked for
    s_nxt.ls = force_low | (run_nxt & pwm_low_req & ~pwm_high_req);
    s_nxt.hs = ~force_low & run_nxt & pwm_high_req;

    // Status outputs move inside the blanking window only under overvoltage
    if (!blank)
    begin
      s_nxt.pg = run_nxt & output_in_regulation;
      s_nxt.cpu_clock_enable_n_n = ~(run_nxt & output_in_regulation);
    end
    else
    begin
      // Held values stand through the blanking window
      s_nxt.pg = s_r.pg;
      s_nxt.cpu_clock_enable_n_n = s_r.cpu_clock_enable_n_n;
    end
    // A latched overvoltage pulls the held values too, so release is clean
    if (s_nxt.ov)
    begin
      s_nxt.pg = 1'b0;
      s_nxt.cpu_clock_enable_n_n = 1'b1;
    end

    // Interrupt events are rising edges of the latches and loss of power good
    events[EV_OV_BIT] = s_nxt.ov & ~s_r.ov;
    events[EV_UV_BIT] = s_nxt.uv & ~s_r.uv;
    events[EV_OT_BIT] = s_nxt.ot & ~s_r.ot;
    events[EV_PG_LOSS_BIT] = s_r.pg & ~s_nxt.pg;
    // Event wins over a clear written in the same cycle
    s_nxt.int_status = (s_r.int_status & ~clr_mask) | events;

    // Capture address phase for a later write
    s_nxt.wr_pend = addr_accept & hwrite;
    if (addr_accept)
    begin
      s_nxt.wr_addr = haddr[ADDR_W-1:0];
    end

    // Read data is built from next-state values so a write just before is seen
    if (addr_accept && !hwrite)
    begin
      case (haddr[ADDR_W-1:0])
        CTRL_OFS:
        begin
          // Only the run enable bit is defined
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rdata[CTRL_RUN_BIT] = s_nxt.run_en;
        end
        STATUS_OFS:
        begin
          // Live latch, mode and pin state
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rdata[ST_OV_BIT] = s_nxt.ov;
          s_nxt.rdata[ST_UV_BIT] = s_nxt.uv;
          s_nxt.rdata[ST_OT_BIT] = s_nxt.ot;
          s_nxt.rdata[ST_BYPASS_BIT] = bypass;
          s_nxt.rdata[ST_BLANK_BIT] = blank;
          s_nxt.rdata[ST_PG_BIT] = s_nxt.pg;
        end
        INT_STATUS_OFS:
        begin
          // Sticky events, including one set this cycle
          s_nxt.rdata = {{(32-NUM_EVENTS){1'b0}}, s_nxt.int_status};
        end
        INT_CLEAR_OFS:
        begin
          // Write-only clear register reads back as zero
          s_nxt.rdata = 32'h0000_0000;
        end
        INT_ENABLE_OFS:
        begin
          s_nxt.rdata = {{(32-NUM_EVENTS){1'b0}}, s_nxt.int_enable};
        end
        default:
        begin
          // Unmapped offsets read as zero
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Single state register; clock enable low freezes everything
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Supply power-on clears every fault latch
      s_r.ov <= 1'b0;
      s_r.uv <= 1'b0;
      s_r.ot <= 1'b0;
      // Registers to their reset values
      s_r.run_en <= CTRL_RUN_RESET;
      s_r.int_status <= '0;
      s_r.int_enable <= INT_ENABLE_RESET;
      // Pins to safe levels: gates off, power good low
      s_r.pg <= 1'b0;
      s_r.cpu_clock_enable_n_n <= 1'b1;
      s_r.ls <= 1'b0;
      s_r.hs <= 1'b0;
      // Bus pipeline idle
      s_r.wr_pend <= 1'b0;
      s_r.wr_addr <= '0;
      s_r.rdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      s_r <= s_nxt;
    end
  end

  // Gate drives come from flip-flops, the high side masked by the low side, never both high
  assign low_side_gate_drive = s_r.ls;
  assign high_side_gate_drive = s_r.hs & ~s_r.ls;

  // Overvoltage overrides the frozen values at once, even while blanked
  assign power_good_out = s_r.pg & ~ov_now;
  assign cpu_clock_enable_n = s_r.cpu_clock_enable_n_n | ov_now;

  // Switching allowed: no latched fault, shutdown released, supply good
  assign converter_running = s_r.run_en & shutdown_n_in & ~supply_lockout
                             & ~s_r.ov & ~s_r.uv & ~s_r.ot;

  // Level interrupt while any enabled sticky bit is set
  assign irq = |(s_r.int_status & s_r.int_enable);

  // Zero-wait slave; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // Read data stands in its flop until the next read is taken
  assign hrdata = s_r.rdata;
endmodule : regulator_fault_latch_logic
`default_nettype wire

// >>> rtl/slew_blank_timer.sv
// Blanking window: active during a transition and a fixed count after it
`timescale 1ns/1ps
`default_nettype none
module slew_blank_timer #(
  parameter int unsigned CYCLES = fault_latch_pkg::BLANK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic slew_active,
  output logic blank
);
  import fault_latch_pkg::*;

  typedef struct packed {
    logic [BLANK_CNT_W-1:0] cnt;
  } timer_s;

  timer_s s_r;
  timer_s s_nxt;

  // Reload while slewing, then count down once the final code is set
  always_comb
  begin
    s_nxt = s_r;
    if (slew_active)
    begin
      s_nxt.cnt = BLANK_CNT_W'(CYCLES);
    end
    else if (s_r.cnt != '0)
    begin
      s_nxt.cnt = s_r.cnt - BLANK_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else if (clk_en)
    begin
      s_r <= s_nxt;
    end
  end

  // Blank stays high for exactly CYCLES edges after slew_active drops
  assign blank = slew_active | (s_r.cnt != '0);
endmodule : slew_blank_timer
`default_nettype wire

// >>> verification/fault_latch_monitor.sv
// Port-level checker for the regulator fault latch block
`timescale 1ns/1ps
`default_nettype none
module fault_latch_monitor #(
  parameter int unsigned BLANK_CYCLES = 32
) (
  input wire logic core_clk, rst_n, clk_en, overvoltage_trip, undervoltage_trip, thermal_trip,
  input wire logic shutdown_n_in, shutdown_hv_detect, supply_lockout, slew_active, pwm_low_req,
  input wire logic low_side_gate_drive, high_side_gate_drive, power_good_out,
  input wire logic cpu_clock_enable_n, converter_running
);
  // No clear source active: shutdown released, supply fine, no bypass, clock on
  wire logic ok = shutdown_n_in && !supply_lockout && !shutdown_hv_detect && clk_en;
  wire logic quiet = clk_en && !overvoltage_trip && !thermal_trip && !pwm_low_req;
  logic [6:0] calm_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Edges since the last transition; saturates so long idle spells never wrap
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) calm_r <= 7'h00;
    else if (clk_en) calm_r <= slew_active ? 7'h00 : calm_r + 7'(calm_r != 7'h7f);
  property p_ov_now;
    overvoltage_trip && !shutdown_hv_detect |-> !power_good_out && cpu_clock_enable_n;
  endproperty
  a_ov_now: assert property (p_ov_now) else $error("ov did not force status");
  property p_ov_hold;
    (overvoltage_trip && ok) ##1 ok [*3] |-> low_side_gate_drive && !high_side_gate_drive;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("ov latch not held");
  property p_uv_trip;
    undervoltage_trip && ok && !slew_active && calm_r > BLANK_CYCLES + 1 |=> !converter_running;
  endproperty
  a_uv_trip: assert property (p_uv_trip) else $error("uv did not stop converter");
  property p_uv_blank;
    undervoltage_trip && slew_active && converter_running && ok && !overvoltage_trip
      && !thermal_trip ##1 ok |-> converter_running;
  endproperty
  a_uv_blank: assert property (p_uv_blank) else $error("uv acted during slew");
  property p_ot_trip;
    thermal_trip && ok |=> low_side_gate_drive && !high_side_gate_drive;
  endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("thermal did not force gates");
  property p_bypass;
    (shutdown_hv_detect && shutdown_n_in && !pwm_low_req && clk_en) [*3] |-> !low_side_gate_drive;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass left a latch set");
  property p_freeze;
    (slew_active && !overvoltage_trip && ok) [*3]
      |-> $stable(power_good_out) && $stable(cpu_clock_enable_n);
  endproperty
  a_freeze: assert property (p_freeze) else $error("status moved while blanked");
  property p_no_shoot;
    !(low_side_gate_drive && high_side_gate_drive);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both gates high");
  property p_sd_clear;
    (!shutdown_n_in && quiet) ##1 quiet ##1 quiet |-> !low_side_gate_drive;
  endproperty
  a_sd_clear: assert property (p_sd_clear) else $error("shutdown left a latch set");
endmodule : fault_latch_monitor
bind regulator_fault_latch_logic fault_latch_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) mon (
  .core_clk, .rst_n, .clk_en, .overvoltage_trip, .undervoltage_trip, .thermal_trip,
  .shutdown_n_in, .shutdown_hv_detect, .supply_lockout, .slew_active, .pwm_low_req,
  .low_side_gate_drive, .high_side_gate_drive, .power_good_out, .cpu_clock_enable_n,
  .converter_running);
`default_nettype wire

// >>> verification/power_stage_model.sv
// Power stage and sensor model that feeds comparator flags back to the block
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input wire logic core_clk, rst_n, hv_test, inj_ov, inj_uv, heat, cool,
  output logic overvoltage_trip, undervoltage_trip, thermal_trip, shutdown_hv_detect
);
  // Die stays hot until it has cooled, so the flag outlives the heat pulse
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) thermal_trip <= 1'b0;
    else thermal_trip <= heat | (thermal_trip & ~cool);
  // A shorted high side keeps the output high for as long as it is injected
  assign overvoltage_trip = inj_ov;
  assign undervoltage_trip = inj_uv;
  assign shutdown_hv_detect = hv_test;
endmodule : power_stage_model
`default_nettype wire

// >>> verification/regulator_fault_latch_logic_test.sv
// Self-checking bench for the regulator fault latch block
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_latch_logic_test;
  import fault_latch_pkg::*;
  localparam int unsigned BL = 4;
  logic core_clk, rst_n, clk_en, shutdown_n_in, supply_lockout, slew_active, hsel, hwrite;
  logic output_in_regulation, pwm_high_req, pwm_low_req, hv_test, inj_ov, inj_uv, heat, cool;
  logic overvoltage_trip, undervoltage_trip, thermal_trip, shutdown_hv_detect, irq, hresp;
  logic low_side_gate_drive, high_side_gate_drive, power_good_out, cpu_clock_enable_n;
  logic converter_running, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, v, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int miscompares, samples_checked;
  regulator_fault_latch_logic #(.BLANK_CYCLES(BL)) dut (.core_clk, .rst_n, .clk_en,
    .overvoltage_trip, .undervoltage_trip, .thermal_trip, .shutdown_n_in, .shutdown_hv_detect,
    .supply_lockout, .slew_active, .output_in_regulation, .pwm_high_req, .pwm_low_req,
    .low_side_gate_drive, .high_side_gate_drive, .power_good_out, .cpu_clock_enable_n,
    .converter_running, .irq, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  power_stage_model ps (.core_clk, .rst_n, .hv_test, .inj_ov, .inj_uv, .heat, .cool,
    .overvoltage_trip, .undervoltage_trip, .thermal_trip, .shutdown_hv_detect);
  // Free-running 50 MHz clock
  always #10 core_clk = ~core_clk;
  function automatic logic [31:0] ev(input int unsigned b);
    return 32'h1 << b;
  endfunction : ev
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
  endtask : step
  // One single transfer; the wait is bounded so a stuck slave ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    v = hrdata;
    if (n >= 50)
    begin
      miscompares++;
      give_verdict();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", v & m, e);
    chk("response", hresp, HRESP_OKAY);
  endtask : rd
  // Shutdown pulse, then look at the settled outputs
  task automatic toggle_sd;
    @(posedge core_clk);
    shutdown_n_in <= 1'b0;
    step(2);
    shutdown_n_in <= 1'b1;
    step(3);
    @(negedge core_clk);
  endtask : toggle_sd
  initial
  begin
    {core_clk, rst_n, supply_lockout, slew_active, pwm_high_req, pwm_low_req} = '0;
    {hsel, hwrite, hv_test, inj_ov, inj_uv, heat, cool, haddr, htrans, hwdata} = '0;
    {clk_en, shutdown_n_in, output_in_regulation} = '1;
    hsize = 3'h2;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'hd7e98b6a));
    step(8);
    rst_n <= 1'b1;
    rd(CTRL_OFS, 32'hffffffff, {31'h0, CTRL_RUN_RESET});
    rd(INT_ENABLE_OFS, 32'hf, {28'h0, INT_ENABLE_RESET});
    rd(8'h40, 32'hffffffff, 32'h0);
    // Enable register round trips with random masks
    repeat (4)
    begin
      rv = $urandom & 32'hf;
      bus(1'b1, INT_ENABLE_OFS, rv);
      rd(INT_ENABLE_OFS, 32'hf, rv);
    end
    bus(1'b1, INT_ENABLE_OFS, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h0);
    @(negedge core_clk);
    chk("running", converter_running, 1'b0);
    bus(1'b1, CTRL_OFS, 32'h1);
    // Overvoltage: immediate status drop, then a latched low side
    @(posedge core_clk);
    inj_ov <= 1'b1;
    @(negedge core_clk);
    chk("power_good", power_good_out, 1'b0);
    chk("clock_en_n", cpu_clock_enable_n, 1'b1);
    @(posedge core_clk);
    inj_ov <= 1'b0;
    step(4);
    @(negedge core_clk);
    chk("low_side", low_side_gate_drive, 1'b1);
    chk("high_side", high_side_gate_drive, 1'b0);
    chk("irq_masked", irq, 1'b0);
    rd(INT_STATUS_OFS, ev(EV_OV_BIT), ev(EV_OV_BIT));
    bus(1'b1, INT_ENABLE_OFS, ev(EV_OV_BIT));
    @(negedge core_clk);
    chk("irq", irq, 1'b1);
    bus(1'b1, INT_CLEAR_OFS, 32'hf);
    @(negedge core_clk);
    chk("irq_clear", irq, 1'b0);
    toggle_sd();
    chk("low_side", low_side_gate_drive, 1'b0);
    // Undervoltage is blanked through the slew and BL edges after it
    @(posedge core_clk);
    slew_active <= 1'b1;
    inj_uv <= 1'b1;
    step(3);
    slew_active <= 1'b0;
    step(BL);
    @(negedge core_clk);
    chk("running", converter_running, 1'b1);
    step(2);
    @(negedge core_clk);
    chk("running", converter_running, 1'b0);
    @(posedge core_clk);
    inj_uv <= 1'b0;
    supply_lockout <= 1'b1;
    step(2);
    supply_lockout <= 1'b0;
    step(2);
    @(negedge core_clk);
    chk("running", converter_running, 1'b1);
    // Thermal latch survives a toggle while still hot
    @(posedge core_clk);
    heat <= 1'b1;
    @(posedge core_clk);
    heat <= 1'b0;
    step(2);
    @(negedge core_clk);
    chk("low_side", low_side_gate_drive, 1'b1);
    chk("high_side", high_side_gate_drive, 1'b0);
    toggle_sd();
    chk("low_side", low_side_gate_drive, 1'b1);
    @(posedge core_clk);
    cool <= 1'b1;
    @(posedge core_clk);
    cool <= 1'b0;
    toggle_sd();
    chk("low_side", low_side_gate_drive, 1'b0);
    // Bypass clears a set latch and masks live flags
    @(posedge core_clk);
    inj_ov <= 1'b1;
    inj_uv <= 1'b1;
    step(2);
    hv_test <= 1'b1;
    step(4);
    @(negedge core_clk);
    chk("low_side", low_side_gate_drive, 1'b0);
    chk("running", converter_running, 1'b1);
    @(posedge core_clk);
    {inj_ov, inj_uv} <= 2'b00;
    @(posedge core_clk);
    hv_test <= 1'b0;
    // Power-on reset in mid-run clears a latch that a toggle could not
    heat <= 1'b1;
    step(3);
    @(negedge core_clk);
    chk("low_side", low_side_gate_drive, 1'b1);
    @(posedge core_clk);
    heat <= 1'b0;
    rst_n <= 1'b0;
    step(2);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("low_side", low_side_gate_drive, 1'b0);
    chk("power_good", power_good_out, 1'b0);
    chk("clock_en_n", cpu_clock_enable_n, 1'b1);
    rd(INT_ENABLE_OFS, 32'hf, {28'h0, INT_ENABLE_RESET});
    // Random traffic with rare faults; gates must never overlap
    repeat (400)
    begin
      @(posedge core_clk);
      {pwm_high_req, pwm_low_req, output_in_regulation} <= 3'($urandom);
      clk_en <= ($urandom % 8) != 0;
      slew_active <= ($urandom % 16) == 0;
      inj_ov <= ($urandom % 32) == 0;
      inj_uv <= ($urandom % 32) == 0;
      shutdown_n_in <= ($urandom % 16) != 0;
      @(negedge core_clk);
      chk("overlap", low_side_gate_drive & high_side_gate_drive, 1'b0);
      if (inj_ov) chk("power_good", power_good_out, 1'b0);
      if (inj_ov) chk("clock_en_n", cpu_clock_enable_n, 1'b1);
    end
    give_verdict();
  end
endmodule : regulator_fault_latch_logic_test
`default_nettype wire
